// ---- fcrd_decoder.sv ----
// What this block does
// - only fast command frames are decoded by this block; block commands pass.
// - the X field of the command word picks the command register.
// - command registers are 16 bits; unused upper bits read zero.
// - fast command bits are set-only from the link side.
// - all command bits are zero after reset.
// - words follow comma K28.3; D1.1 resets the bunch counter.
// - D2.1 starts acquisition with internal trigger.
// - D2.2 starts with external trigger; D2.3 stops acquisition.
// - D3.1 halts readout; D3.2 resumes it.
// - detector ranges and identifier range are passed out undecoded.
// - D11.1 to D11.4 start calibration runs, four flavours.
// - bunch reset bit holds four clock cycles, then self-clears.
// - command registers have no read path; status shown separately.
// - a sticky status bit reports bunch-counter reset.
// - stop bit halts acquisition and self-clears after execution.
// - external start bit starts acquisition and self-clears.
// - internal start bit starts acquisition and self-clears.
// - any start moves the device to active mode.
// - resume bit resumes readout and self-clears.
// - halt bit halts readout and self-clears.
// - a zero bit causes no action.
// - comma K28.3 marks the next data symbol as command word.
// - symbol is X in bits 7..3 followed by Y in bits 2..0.
// - block transfer type modifier forwarded as register address.
`timescale 1ns/1ps
`default_nettype none
module fcrd_decoder (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire fcrd_pkg::fcrd_sym_s link_sym,
   input wire logic status_clear,
   input wire logic bt_cmd_valid,
   input wire logic [15:0] bt_type_modifier,
   output logic bunch_counter_clear_bit,
   output logic acq_start_int,
   output logic acq_start_ext,
   output logic acq_stop,
   output logic ro_halt,
   output logic ro_resume,
   output logic [3:0] cal_start,
   output logic active_mode,
   output logic ro_halted,
   output logic status_bunch_reset,
   output logic reserved_cmd_valid,
   output fcrd_pkg::fcrd_sym_s reserved_cmd,
   output logic bt_sel_valid,
   output logic [15:0] bt_sel_addr
);
   // ----------------------------------------------------------------
   // link sampling
   // ----------------------------------------------------------------
   // link clock is 8x slower than clk, so plain edge finding suffices
   logic lclk_s1, lclk_s2, lclk_s3;
   fcrd_pkg::fcrd_sym_s sym_s1, sym_s2;
   logic link_rise;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_s3 <= 1'b0;
         sym_s1 <= '0;
         sym_s2 <= '0;
      end else begin
         lclk_s1 <= link_clk;
         lclk_s2 <= lclk_s1;
         lclk_s3 <= lclk_s2;
         sym_s1 <= link_sym;
         sym_s2 <= sym_s1;
      end
   end

   assign link_rise = lclk_s2 && !lclk_s3;

   // ----------------------------------------------------------------
   // frame parsing
   // ----------------------------------------------------------------
   fcrd_pkg::fcrd_parse_e parse_reg;
   logic word_fire;
   logic [4:0] wx;
   logic [2:0] wy;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         parse_reg <= fcrd_pkg::PARSE_IDLE;
      end else if (link_rise) begin
         case (parse_reg)
            fcrd_pkg::PARSE_IDLE: begin
               if (fcrd_pkg::fcrd_is_comma(sym_s2)) begin
                  parse_reg <= fcrd_pkg::PARSE_ARMED;
               end
            end
            fcrd_pkg::PARSE_ARMED: begin
               if (!fcrd_pkg::fcrd_is_comma(sym_s2)) begin
                  parse_reg <= fcrd_pkg::PARSE_IDLE;
               end
            end
            default: parse_reg <= fcrd_pkg::PARSE_IDLE;
         endcase
      end
   end

   // a K symbol other than a repeated comma aborts; only a D symbol is a command
   assign word_fire = link_rise && (parse_reg == fcrd_pkg::PARSE_ARMED) &&
                      !sym_s2.is_k;
   assign wx = sym_s2.x;
   assign wy = sym_s2.y;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic set_bcr, set_sint, set_sext, set_stop, set_halt, set_res;
   logic [3:0] set_cal;
   logic cal_hit, known;

   always_comb begin
      set_bcr = word_fire && (wx == fcrd_pkg::X_BCR) &&
                (wy == fcrd_pkg::Y_BCR);
      set_sint = word_fire && (wx == fcrd_pkg::X_ACQ) &&
                 (wy == fcrd_pkg::Y_START_INT);
      set_sext = word_fire && (wx == fcrd_pkg::X_ACQ) &&
                 (wy == fcrd_pkg::Y_START_EXT);
      set_stop = word_fire && (wx == fcrd_pkg::X_ACQ) &&
                 (wy == fcrd_pkg::Y_STOP);
      set_halt = word_fire && (wx == fcrd_pkg::X_RO) &&
                 (wy == fcrd_pkg::Y_RO_HALT);
      set_res = word_fire && (wx == fcrd_pkg::X_RO) &&
                (wy == fcrd_pkg::Y_RO_RESUME);
      cal_hit = word_fire && (wx == fcrd_pkg::X_CAL) &&
                (wy >= fcrd_pkg::Y_CAL_LO) &&
                (wy <= fcrd_pkg::Y_CAL_HI);
      set_cal = 4'h0;
      if (cal_hit) begin
         set_cal[2'(wy - fcrd_pkg::Y_CAL_LO)] = 1'b1;
      end
      known = set_bcr || set_sint || set_sext || set_stop ||
              set_halt || set_res || cal_hit;
   end

   // ----------------------------------------------------------------
   // command registers, set-only from the link, cleared by execution
   // ----------------------------------------------------------------
   // no read path exists; software sees only the status outputs
   logic [15:0] bcr_cmd_reg, acq_cmd_reg, ro_cmd_reg, cal_cmd_reg;
   logic [2:0] bcr_cnt_reg;

   // a fresh D1.1 during the hold restarts the four-cycle window
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bcr_cmd_reg <= fcrd_pkg::CMD_RESET;
         bcr_cnt_reg <= 3'h0;
      end else if (set_bcr) begin
         bcr_cmd_reg[fcrd_pkg::BCR_BIT] <= 1'b1;
         bcr_cnt_reg <= fcrd_pkg::BCR_HOLD_CYCLES;
      end else if (bcr_cmd_reg[fcrd_pkg::BCR_BIT]) begin
         if (bcr_cnt_reg == fcrd_pkg::BCR_LAST) begin
            bcr_cmd_reg[fcrd_pkg::BCR_BIT] <= 1'b0;
         end
         bcr_cnt_reg <= bcr_cnt_reg - 3'h1;
      end
   end

   // each set bit executes in the cycle it is seen, then clears;
   // a new set in that same cycle wins over the clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acq_cmd_reg <= fcrd_pkg::CMD_RESET;
      end else begin
         acq_cmd_reg[fcrd_pkg::START_INT_BIT] <= set_sint;
         acq_cmd_reg[fcrd_pkg::START_EXT_BIT] <= set_sext;
         acq_cmd_reg[fcrd_pkg::STOP_BIT] <= set_stop;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ro_cmd_reg <= fcrd_pkg::CMD_RESET;
      end else begin
         ro_cmd_reg[fcrd_pkg::RO_HALT_BIT] <= set_halt;
         ro_cmd_reg[fcrd_pkg::RO_RESUME_BIT] <= set_res;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cal_cmd_reg <= fcrd_pkg::CMD_RESET;
      end else begin
         cal_cmd_reg[fcrd_pkg::CAL_BITS-1:0] <= set_cal;
      end
   end

   // ----------------------------------------------------------------
   // execution and state
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_mode <= 1'b0;
      end else if (acq_cmd_reg[fcrd_pkg::STOP_BIT]) begin
         active_mode <= 1'b0;
      end else if (acq_cmd_reg[fcrd_pkg::START_INT_BIT] ||
                   acq_cmd_reg[fcrd_pkg::START_EXT_BIT] ||
                   (cal_cmd_reg[fcrd_pkg::CAL_BITS-1:0] != 4'h0)) begin
         active_mode <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ro_halted <= 1'b0;
      end else if (ro_cmd_reg[fcrd_pkg::RO_HALT_BIT]) begin
         ro_halted <= 1'b1;
      end else if (ro_cmd_reg[fcrd_pkg::RO_RESUME_BIT]) begin
         ro_halted <= 1'b0;
      end
   end

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_bunch_reset <= 1'b0;
      end else if (set_bcr) begin
         status_bunch_reset <= 1'b1;
      end else if (status_clear) begin
         status_bunch_reset <= 1'b0;
      end
   end

   // reserved ranges go out for detector-specific logic elsewhere
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reserved_cmd_valid <= 1'b0;
         reserved_cmd <= '0;
      end else begin
         reserved_cmd_valid <= word_fire && !known &&
            (fcrd_pkg::fcrd_in_range(wx, fcrd_pkg::DET_X_LO,
                                     fcrd_pkg::DET_X_HI) ||
             fcrd_pkg::fcrd_in_range(wx, fcrd_pkg::ID_X_LO,
                                     fcrd_pkg::ID_X_HI));
         if (word_fire) begin
            reserved_cmd <= sym_s2;
         end
      end
   end

   // block commands are not decoded here, only their address passes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bt_sel_valid <= 1'b0;
         bt_sel_addr <= 16'h0000;
      end else begin
         bt_sel_valid <= bt_cmd_valid;
         if (bt_cmd_valid) begin
            bt_sel_addr <= bt_type_modifier;
         end
      end
   end

   // zero bits drive nothing: outputs are the bits themselves
   assign bunch_counter_clear_bit = bcr_cmd_reg[fcrd_pkg::BCR_BIT];
   assign acq_start_int = acq_cmd_reg[fcrd_pkg::START_INT_BIT];
   assign acq_start_ext = acq_cmd_reg[fcrd_pkg::START_EXT_BIT];
   assign acq_stop = acq_cmd_reg[fcrd_pkg::STOP_BIT];
   assign ro_halt = ro_cmd_reg[fcrd_pkg::RO_HALT_BIT];
   assign ro_resume = ro_cmd_reg[fcrd_pkg::RO_RESUME_BIT];
   assign cal_start = cal_cmd_reg[fcrd_pkg::CAL_BITS-1:0];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   bcr_hold_four_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(bunch_counter_clear_bit) |-> bunch_counter_clear_bit[*4])
      else $error("bunch reset shorter than four cycles");

   bcr_self_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(bunch_counter_clear_bit) ##3 !set_bcr && !$past(set_bcr) &&
      !$past(set_bcr, 2) && !$past(set_bcr, 3) |=> !bunch_counter_clear_bit)
      else $error("bunch reset not cleared after four cycles");

   start_self_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      (acq_start_int || acq_start_ext) && !set_sint && !set_sext |=>
      !acq_start_int && !acq_start_ext)
      else $error("start bit did not clear itself");

   start_active_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      (acq_start_int || acq_start_ext || cal_start != 4'h0) |=> active_mode)
      else $error("start did not enter active mode");

   stop_leaves_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      acq_stop |=> !active_mode && !acq_stop)
      else $error("stop did not leave active mode");

   halt_resume_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      (ro_halt |=> ro_halted) and (ro_resume && !ro_halt |=> !ro_halted))
      else $error("readout halt or resume not executed");

   comma_gate_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(acq_start_int) |-> $past(parse_reg) == fcrd_pkg::PARSE_ARMED)
      else $error("command taken without preceding comma");

   unknown_quiet_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      word_fire && !(wx == fcrd_pkg::X_BCR && wy == fcrd_pkg::Y_BCR) &&
      !(wx == fcrd_pkg::X_ACQ && wy >= fcrd_pkg::Y_START_INT &&
        wy <= fcrd_pkg::Y_STOP) &&
      !(wx == fcrd_pkg::X_RO && wy >= fcrd_pkg::Y_RO_HALT &&
        wy <= fcrd_pkg::Y_RO_RESUME) &&
      !(wx == fcrd_pkg::X_CAL && wy >= fcrd_pkg::Y_CAL_LO &&
        wy <= fcrd_pkg::Y_CAL_HI) |=>
      !$rose(bunch_counter_clear_bit) && !acq_start_int && !acq_start_ext &&
      !acq_stop && !ro_halt && !ro_resume && cal_start == 4'h0)
      else $error("unassigned word changed a command bit");

   reserved_zero_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      acq_cmd_reg[15:3] == 13'h0 && ro_cmd_reg[15:2] == 14'h0 &&
      bcr_cmd_reg[15:1] == 15'h0 && cal_cmd_reg[15:4] == 12'h0)
      else $error("reserved command bits not zero");

   status_set_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      set_bcr |=> status_bunch_reset ##0 bunch_counter_clear_bit)
      else $error("bunch reset status not raised");
endmodule
`default_nettype wire

// ---- fcrd_decoder_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcrd_decoder_tb_top;
   // ------------------------------------------
   // signals and bookkeeping
   // ------------------------------------------
   logic clk, reset_n, link_clk, status_clear, bt_cmd_valid;
   fcrd_pkg::fcrd_sym_s link_sym, rsv_cmd;
   logic [15:0] bt_type_modifier, bt_sel_addr;
   logic bcr_bit, st_int, st_ext, stop, halt, resume, act, halted, stat;
   logic [3:0] cal;
   logic rsv_valid, bt_sel_valid, bcr_prev;
   logic exp_act, exp_halt, exp_stat;
   logic [31:0] r;
   logic [15:0] addr_q [$];
   int miscompares, check_count, cycles, seed, bcr_high, bcr_exp;
   int pulse_cnt [11];
   int exp_cnt [11];
   logic [7:0] tbl [14] = '{8'h09, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1A,
      8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h28, 8'h78, 8'h5D, 8'h10};
   wire logic [10:0] pv = {rsv_valid, cal, resume, halt, stop, st_ext,
      st_int, bcr_bit & ~bcr_prev};
   localparam fcrd_pkg::fcrd_sym_s COMMA = {1'b1, fcrd_pkg::COMMA_X,
      fcrd_pkg::COMMA_Y};

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   fcrd_link_model link_u (.link_clk(link_clk), .link_sym(link_sym));

   fcrd_decoder dut_u (
      .clk(clk), .reset_n(reset_n), .link_clk(link_clk),
      .link_sym(link_sym), .status_clear(status_clear),
      .bt_cmd_valid(bt_cmd_valid), .bt_type_modifier(bt_type_modifier),
      .bunch_counter_clear_bit(bcr_bit), .acq_start_int(st_int),
      .acq_start_ext(st_ext), .acq_stop(stop), .ro_halt(halt),
      .ro_resume(resume), .cal_start(cal), .active_mode(act),
      .ro_halted(halted), .status_bunch_reset(stat),
      .reserved_cmd_valid(rsv_valid), .reserved_cmd(rsv_cmd),
      .bt_sel_valid(bt_sel_valid), .bt_sel_addr(bt_sel_addr)
   );

   // counting pulses here means no pulse slips past a late compare
   always @(posedge clk) begin
      cycles <= cycles + 1;
      bcr_prev <= bcr_bit;
      if (bcr_bit === 1'b1)
         bcr_high <= bcr_high + 1;
      for (int i = 0; i < 11; i++)
         if (pv[i] === 1'b1)
            pulse_cnt[i] <= pulse_cnt[i] + 1;
      if (bt_sel_valid === 1'b1)
         addr_q.push_back(bt_sel_addr);
      if (cycles == 10000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ------------------------------------------
   // expectation and compare helpers
   // ------------------------------------------
   function automatic int cls(input logic [4:0] x, input logic [2:0] y);
      if (x == fcrd_pkg::X_BCR && y == fcrd_pkg::Y_BCR) return 0;
      if (x == fcrd_pkg::X_ACQ && y >= 3'h1 && y <= 3'h3) return y;
      if (x == fcrd_pkg::X_RO && y >= 3'h1 && y <= 3'h2) return 3 + y;
      if (x == fcrd_pkg::X_CAL && y >= 3'h1 && y <= 3'h4) return 5 + y;
      if (x >= fcrd_pkg::DET_X_LO && x <= fcrd_pkg::DET_X_HI) return 10;
      if (x >= fcrd_pkg::ID_X_LO && x <= fcrd_pkg::ID_X_HI) return 10;
      return 11;
   endfunction

   task automatic chk_cnt(input int got, input int exp, input string msg);
      check_count++;
      if (got != exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s %0d/%0d", $time, msg, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp,
                          input string msg);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t %s %h/%h", $time, msg, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check_all();
      for (int i = 0; i < 11; i++)
         chk_cnt(pulse_cnt[i], exp_cnt[i], "pulses");
      chk_cnt(bcr_high, bcr_exp, "bunch clear cycles");
      chk_vec({15'h0000, act}, {15'h0000, exp_act}, "active");
      chk_vec({15'h0000, halted}, {15'h0000, exp_halt}, "halted");
      chk_vec({15'h0000, stat}, {15'h0000, exp_stat}, "status");
   endtask

   task automatic frame(input fcrd_pkg::fcrd_sym_s a,
                        input fcrd_pkg::fcrd_sym_s b);
      link_u.send_frame(a, b);
      repeat (6) @(negedge clk);
   endtask

   task automatic cmd(input logic [7:0] w);
      int c;
      c = cls(w[7:3], w[2:0]);
      frame(COMMA, {1'b0, w});
      if (c < 11) exp_cnt[c]++;
      if (c == 0) exp_stat = 1'b1;
      if (c == 0) bcr_exp += 4;
      if (c inside {1, 2, 6, 7, 8, 9}) exp_act = 1'b1;
      if (c == 3) exp_act = 1'b0;
      if (c == 4) exp_halt = 1'b1;
      if (c == 5) exp_halt = 1'b0;
      check_all();
      if (c < 11)
         chk_vec({7'h00, rsv_cmd}, {8'h00, w}, "word");
   endtask

   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      seed = 98;
      reset_n = 1'b0;
      status_clear = 1'b0;
      bt_cmd_valid = 1'b0;
      bt_type_modifier = 16'h0000;
      bcr_prev = 1'b0;
      {exp_act, exp_halt, exp_stat} = 3'h0;
      foreach (pulse_cnt[i]) pulse_cnt[i] = 0;
      foreach (exp_cnt[i]) exp_cnt[i] = 0;
      repeat (12) @(negedge clk);
      chk_vec({1'b0, bcr_bit, st_int, st_ext, stop, halt, resume, cal, act,
         halted, stat, rsv_valid, bt_sel_valid}, 16'h0000, "reset");
      reset_n = 1'b1;
      foreach (tbl[i]) cmd(tbl[i]);
      status_clear = 1'b1;
      @(negedge clk);
      status_clear = 1'b0;
      exp_stat = 1'b0;
      @(negedge clk);
      check_all();
      // words without a live comma, and a K word after a comma, must do nothing
      frame({1'b0, 8'h09}, {1'b0, 8'h11});
      frame(COMMA, {1'b1, 8'hE5});
      frame({1'b0, 8'h11}, {1'b0, 8'h12});
      check_all();
      repeat (150) begin
         r = $random(seed);
         cmd(r[7:0]);
      end
      // mid-run reset must clear every command, mode, status and valid output again
      reset_n = 1'b0;
      @(negedge clk);
      chk_vec({1'b0, bcr_bit, st_int, st_ext, stop, halt, resume, cal, act,
         halted, stat, rsv_valid, bt_sel_valid}, 16'h0000, "reset");
      reset_n = 1'b1;
      {exp_act, exp_halt, exp_stat} = 3'h0;
      // back to back block selections
      repeat (20) begin
         r = $random(seed);
         bt_cmd_valid = 1'b1;
         bt_type_modifier = r[15:0];
         @(negedge clk);
         bt_type_modifier = r[31:16];
         @(negedge clk);
         bt_cmd_valid = 1'b0;
         repeat (3) @(negedge clk);
         chk_cnt(addr_q.size(), 2, "block pulses");
         chk_vec(addr_q[0], r[15:0], "block addr");
         chk_vec(addr_q[1], r[31:16], "block addr");
         addr_q.delete();
      end
      check_all();
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- fcrd_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fcrd_link_model (
   output logic link_clk,
   output fcrd_pkg::fcrd_sym_s link_sym
);
   // ------------------------------------------
   // aggregator side of the fast command link
   // ------------------------------------------
   // clock stands still between frames: only sent symbols are clocked
   initial begin
      link_clk = 1'b0;
      link_sym = '0;
   end
   // symbol set while the clock is low, so it is stable at the rise
   task automatic send_sym(input fcrd_pkg::fcrd_sym_s s);
      link_sym = s;
      #40;
      link_clk = 1'b1;
      #40;
      link_clk = 1'b0;
   endtask
   task automatic send_frame(input fcrd_pkg::fcrd_sym_s k,
                             input fcrd_pkg::fcrd_sym_s d);
      send_sym(k);
      send_sym(d);
      // released line must not keep showing the word
      link_sym = ~d;
   endtask
endmodule
`default_nettype wire

// ---- fcrd_pkg.sv ----
`default_nettype none
package fcrd_pkg;
   // ----------------------------------------------------------------
   // symbol codes, X is five bits and Y three bits of the 8-bit symbol
   // ----------------------------------------------------------------
   localparam logic [4:0] COMMA_X = 5'h1C;
   localparam logic [2:0] COMMA_Y = 3'h3;
   localparam logic [4:0] X_BCR = 5'h01;
   localparam logic [4:0] X_ACQ = 5'h02;
   localparam logic [4:0] X_RO = 5'h03;
   localparam logic [4:0] X_CAL = 5'h0B;
   localparam logic [2:0] Y_BCR = 3'h1;
   localparam logic [2:0] Y_START_INT = 3'h1;
   localparam logic [2:0] Y_START_EXT = 3'h2;
   localparam logic [2:0] Y_STOP = 3'h3;
   localparam logic [2:0] Y_RO_HALT = 3'h1;
   localparam logic [2:0] Y_RO_RESUME = 3'h2;
   localparam logic [2:0] Y_CAL_LO = 3'h1;
   localparam logic [2:0] Y_CAL_HI = 3'h4;
   localparam logic [4:0] DET_X_LO = 5'h05;
   localparam logic [4:0] DET_X_HI = 5'h0D;
   localparam logic [4:0] ID_X_LO = 5'h0F;
   localparam logic [4:0] ID_X_HI = 5'h11;
   // ----------------------------------------------------------------
   // command register layout
   // ----------------------------------------------------------------
   localparam logic [15:0] CMD_RESET = 16'h0000;
   localparam int BCR_BIT = 0;
   localparam int START_INT_BIT = 0;
   localparam int START_EXT_BIT = 1;
   localparam int STOP_BIT = 2;
   localparam int RO_HALT_BIT = 0;
   localparam int RO_RESUME_BIT = 1;
   localparam int CAL_BITS = 4;
   localparam logic [2:0] BCR_HOLD_CYCLES = 3'h4;
   localparam logic [2:0] BCR_LAST = 3'h1;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic is_k;
      logic [4:0] x;
      logic [2:0] y;
   } fcrd_sym_s;
   typedef enum logic {PARSE_IDLE, PARSE_ARMED} fcrd_parse_e;

   function automatic logic fcrd_in_range(input logic [4:0] v,
                                          input logic [4:0] lo,
                                          input logic [4:0] hi);
      fcrd_in_range = (v >= lo) && (v <= hi);
   endfunction

   function automatic logic fcrd_is_comma(input fcrd_sym_s s);
      fcrd_is_comma = s.is_k && (s.x == COMMA_X) && (s.y == COMMA_Y);
   endfunction
endpackage
`default_nettype wire
